// ==== logic/dmr_pkg.sv ====
// Package: mode word layout, encodings and timing counts for the mode register block
package dmr_pkg;

  // Command bus encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;

  // Mode word geometry
  localparam int MODE_W = 17;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  localparam logic [2:0] BANK_MODE_WORD = 3'h0;

  // Field positions
  localparam int BLEN_LSB = 0;
  localparam int ORDER_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int TEST_BIT = 7;
  localparam int LOOP_RST_BIT = 8;
  localparam int WR_LSB = 9;
  localparam int WAKE_BIT = 12;

  // Field encodings
  localparam logic [2:0] BLEN_FOUR = 3'h2;
  localparam logic [2:0] BLEN_EIGHT = 3'h3;
  localparam logic [2:0] LAT_MIN = 3'h3;
  localparam logic [2:0] LAT_MAX = 3'h7;

  // Reset value of the stored word: length four, sequential, latency 3, recovery 2
  localparam logic [16:0] MODE_RESET = 17'h00232;

  // Latency count width
  localparam int CNT_W = 4;

  // Decoded view of the mode word
  typedef struct packed {
    logic eight;
    logic interleave;
    logic [2:0] latency;
    logic [3:0] recover;
    logic slow_wake;
  } dmr_mode_t;

  // Burst column output
  typedef struct packed {
    logic valid;
    logic is_write;
    logic [2:0] col;
  } dmr_beat_t;

endpackage : dmr_pkg

// ==== logic/dmr_order.sv ====
// Column order generator for one beat of a burst
`timescale 1ns/100ps
module dmr_order
  import dmr_pkg::*;
(
  // Burst setup
  input wire logic [2:0] start_col,
  input wire logic eight,
  input wire logic interleave,
  // Beat index
  input wire logic [2:0] beat,
  // Column out
  output logic [2:0] col
);

  // Interleave: start XOR counter; sequential: nibble-based wrap
  wire [1:0] low_seq = 2'(start_col[1:0] + beat[1:0]);
  wire hi_bit = eight ? (start_col[2] ^ beat[2]) : start_col[2];
  wire [2:0] col_int = eight ? (start_col ^ beat) : {start_col[2], start_col[1:0] ^ beat[1:0]};
  wire [2:0] col_seq = {hi_bit, low_seq};
  assign col = interleave ? col_int : col_seq; // [R10] [R7]

endmodule : dmr_order

// ==== logic/dmr_mode_reg.sv ====
// Mode register: load decode, burst sequencing, read latency and auto precharge timing
`timescale 1ns/100ps
//
// Contract
// R1: Controller loads every field on each mode load.
// R2: Mode word holds until reloaded; loop reset bit clears itself.
// R3: Reloading the mode word never touches array contents.
// R4: Mode load only when all banks idle and no burst running.
// R5: Controller waits the mode load gap after a mode load.
// R6: Bits 0-2 select burst length four or eight.
// R7: Burst wraps inside aligned block of burst length.
// R8: One burst length governs reads and writes.
// R9: Bit 3 selects sequential or interleaved ordering.
// R10: Interleave is start XOR counter; sequential wraps within nibble.
// R11: Bit 7 high programs nothing else, enters test mode.
// R12: Bit 8 high pulses loop reset, then clears itself.
// R13: Controller waits 200 clocks after loop reset before reading.
// R14: Auto precharge starts recovery count clocks after last write data.
// R15: Controller programs recovery 2-8 and avoids reserved encodings.
// R16: Bit 12 selects fast or slow exit for active power down.
// R17: Precharge power down exit ignores bit 12.
// R18: Bits 4-6 give read latency 3 to 7 whole clocks.
// R19: First read data appears latency edges after read registers.
// R20: Read accepted early and held for the additive latency.
// R21: Controller loads zero into bit 16 and bits above 12.
// R22: Bank address selects mode register; address carries fields.
// R23: Length code 010 four, 011 eight; type 0 sequential.
// R24: Latency field binary; recovery field holds count minus one.
module dmr_mode_reg
  import dmr_pkg::*;
#(
  parameter int EXTRA_LAT_MAX = 6
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Command pins {cs_n, ras_n, cas_n, we_n}
  input wire logic [3:0] cmd,
  input wire logic [BANK_W-1:0] bank_addr,
  input wire logic [ADDR_W-1:0] addr,
  // Additive latency from the extended register
  input wire logic [2:0] posted_extra_latency,
  // Active power down request (precharge power down is not signalled here)
  input wire logic pd_active,
  // Outputs
  output logic [MODE_W-1:0] operating_mode_word,
  output dmr_mode_t mode_fields,
  output logic test_mode,
  output logic loop_reset_pulse,
  output dmr_beat_t beat_out,
  output logic read_data_start,
  output logic auto_precharge_start,
  output logic slow_wake_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire load_cmd = (cmd == CMD_MODE_LOAD) && (bank_addr == BANK_MODE_WORD); // [R22]
  wire load_test = load_cmd && addr[TEST_BIT];
  wire load_norm = load_cmd && !addr[TEST_BIT]; // [R11]
  wire rd_cmd = (cmd == CMD_READ);
  wire wr_cmd = (cmd == CMD_WRITE);
  wire ap_flag = addr[10];

  ////////////////////////////////////////////////////////////////////////////
  // Mode word storage; loop reset bit never stored
  logic [MODE_W-1:0] mode_r, mode_nxt;
  logic test_r, loop_r;
  assign mode_nxt = load_norm ? {4'h0, addr[12:0] & 13'h1eff} : mode_r; // [R2] [R12] [R21]
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      mode_r <= MODE_RESET;
      test_r <= 1'b0;
      loop_r <= 1'b0;
    end
    else if (clk_en)
    begin
      mode_r <= mode_nxt; // [R2] [R3]
      test_r <= load_cmd ? load_test : test_r; // [R11]
      loop_r <= load_norm && addr[LOOP_RST_BIT]; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  dmr_mode_t fld;
  assign fld.eight = (mode_r[BLEN_LSB +: 3] == BLEN_EIGHT); // [R6] [R23] [R8]
  assign fld.interleave = mode_r[ORDER_BIT]; // [R9] [R23]
  assign fld.latency = mode_r[LAT_LSB +: 3]; // [R18] [R24]
  assign fld.recover = 4'(mode_r[WR_LSB +: 3]) + 4'h1; // [R24] [R14]
  assign fld.slow_wake = mode_r[WAKE_BIT]; // [R16]

  ////////////////////////////////////////////////////////////////////////////
  // Posted read/write delay line, indexed by additive latency
  logic [EXTRA_LAT_MAX:0] pend_v_r;
  logic [EXTRA_LAT_MAX:0] pend_w_r;
  logic [EXTRA_LAT_MAX:0] pend_ap_r;
  logic [2:0] pend_col_r [EXTRA_LAT_MAX:0];
  wire [EXTRA_LAT_MAX:0] pend_v_nxt;
  wire [EXTRA_LAT_MAX:0] pend_w_nxt;
  wire [EXTRA_LAT_MAX:0] pend_ap_nxt;
  wire [2:0] pend_col_nxt [EXTRA_LAT_MAX:0];
  wire [2:0] al = posted_extra_latency;
  genvar gi;
  generate
    for (gi = 0; gi <= EXTRA_LAT_MAX; gi = gi + 1)
    begin : g_post
      wire here = (rd_cmd || wr_cmd) && (al == 3'(gi));
      wire from_up;
      wire up_w, up_ap;
      wire [2:0] up_col;
      if (gi == EXTRA_LAT_MAX)
      begin : g_top
        assign from_up = 1'b0;
        assign up_w = 1'b0;
        assign up_ap = 1'b0;
        assign up_col = 3'h0;
      end
      else
      begin : g_mid
        assign from_up = pend_v_r[gi+1];
        assign up_w = pend_w_r[gi+1];
        assign up_ap = pend_ap_r[gi+1];
        assign up_col = pend_col_r[gi+1];
      end
      // Enter at the stage matching the additive latency, else shift down
      assign pend_v_nxt[gi] = here | from_up; // [R20]
      assign pend_w_nxt[gi] = here ? wr_cmd : up_w;
      assign pend_ap_nxt[gi] = here ? ap_flag : up_ap;
      assign pend_col_nxt[gi] = here ? addr[2:0] : up_col;
    end
  endgenerate

  // Delay line registers, one driver for the whole line
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      pend_v_r <= '0;
      pend_w_r <= '0;
      pend_ap_r <= '0;
      pend_col_r <= '{default: 3'h0};
    end
    else if (clk_en)
    begin
      pend_v_r <= pend_v_nxt; // [R20]
      pend_w_r <= pend_w_nxt;
      pend_ap_r <= pend_ap_nxt;
      pend_col_r <= pend_col_nxt;
    end
  end

  // Internal command issued at the registration edge plus additive latency
  wire int_v = pend_v_r[0];
  wire int_w = pend_w_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Read latency countdown: data at issue edge + latency
  logic [CNT_W-1:0] lat_cnt_r;
  logic lat_busy_r;
  wire lat_load = int_v && !int_w;
  wire lat_done = lat_busy_r && (lat_cnt_r == 4'h1);
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      lat_cnt_r <= 4'h0;
      lat_busy_r <= 1'b0;
    end
    else if (clk_en)
    begin
      lat_cnt_r <= lat_load ? 4'(fld.latency) - 4'h1 : lat_cnt_r - 4'(lat_busy_r); // [R19]
      lat_busy_r <= lat_load ? (fld.latency > 3'h1) : (lat_busy_r && !lat_done);
    end
  end
  wire data_start_nxt = lat_done || (lat_load && fld.latency == 3'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Burst beat sequencer
  logic [2:0] beat_r, start_r;
  logic burst_r, bw_r, bap_r;
  wire [2:0] last_beat = fld.eight ? 3'h7 : 3'h3; // [R8]
  wire burst_go = int_v;
  wire burst_end = burst_r && (beat_r == last_beat);
  wire [2:0] col_w;
  dmr_order u_order (
    .start_col(start_r),
    .eight(fld.eight),
    .interleave(fld.interleave),
    .beat(beat_r),
    .col(col_w)
  );
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      beat_r <= 3'h0;
      start_r <= 3'h0;
      burst_r <= 1'b0;
      bw_r <= 1'b0;
      bap_r <= 1'b0;
    end
    else if (clk_en)
    begin
      beat_r <= burst_go ? 3'h0 : (burst_r ? beat_r + 3'h1 : beat_r);
      start_r <= burst_go ? pend_col_r[0] : start_r; // [R7]
      burst_r <= burst_go | (burst_r && !burst_end);
      bw_r <= burst_go ? int_w : bw_r;
      bap_r <= burst_go ? pend_ap_r[0] : (burst_end ? 1'b0 : bap_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write recovery countdown after last write beat
  logic [CNT_W-1:0] wr_cnt_r;
  logic wr_busy_r;
  wire wr_arm = burst_end && bw_r && bap_r;
  wire wr_done = wr_busy_r && (wr_cnt_r == 4'h1);
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      wr_cnt_r <= 4'h0;
      wr_busy_r <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_cnt_r <= wr_arm ? fld.recover : wr_cnt_r - 4'(wr_busy_r); // [R14]
      wr_busy_r <= wr_arm | (wr_busy_r && !wr_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      operating_mode_word <= MODE_RESET;
      mode_fields <= '0;
      test_mode <= 1'b0;
      loop_reset_pulse <= 1'b0;
      beat_out <= '0;
      read_data_start <= 1'b0;
      auto_precharge_start <= 1'b0;
      slow_wake_sel <= 1'b0;
    end
    else if (clk_en)
    begin
      operating_mode_word <= mode_r;
      mode_fields <= fld;
      test_mode <= test_r; // [R11]
      loop_reset_pulse <= loop_r; // [R12]
      beat_out <= '{valid: burst_r, is_write: bw_r, col: col_w}; // [R7] [R10]
      read_data_start <= data_start_nxt; // [R19]
      auto_precharge_start <= wr_done; // [R14]
      slow_wake_sel <= pd_active && fld.slow_wake; // [R16] [R17]
    end
  end

endmodule : dmr_mode_reg

// ==== tb/dmr_mode_reg_monitor.sv ====
// Checker bound to the mode register ports
`timescale 1ns/100ps
module dmr_mode_reg_monitor
  import dmr_pkg::*;
(
  // Clock and inputs
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [3:0] cmd,
  input wire logic [BANK_W-1:0] bank_addr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic pd_active,
  // Outputs watched
  input wire logic [MODE_W-1:0] operating_mode_word,
  input wire dmr_mode_t mode_fields,
  input wire logic test_mode,
  input wire logic loop_reset_pulse,
  input wire logic slow_wake_sel
);
  ////////////////////////////////////////
  logic [1:0] up_r;
  // Load decode helpers
  wire cm = clk_en && cmd == CMD_MODE_LOAD;
  wire ld = cm && bank_addr == BANK_MODE_WORD;
  wire lr = ld && addr[8] && !addr[7];
  // Edges since reset release
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  property p_clr; operating_mode_word[16:13] == 4'h0 && !operating_mode_word[8]; endproperty
  a_clr: assert property (p_clr) else $error("self-clearing bit held");
  property p_load; ld && !addr[7] |-> ##2 operating_mode_word == ({3'h0, $past(addr, 2)} & 17'h01eff); endproperty
  a_load: assert property (p_load) else $error("word not loaded");
  property p_pulse; lr |-> ##2 loop_reset_pulse ##1 !loop_reset_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("loop reset pulse wrong");
  property p_cause; loop_reset_pulse |-> $past(lr, 2); endproperty
  a_cause: assert property (p_cause) else $error("stray loop reset");
  property p_test; ld && addr[7] |-> ##2 test_mode && $stable(operating_mode_word); endproperty
  a_test: assert property (p_test) else $error("test load programmed");
  property p_bank; cm && bank_addr != BANK_MODE_WORD |=> ##1 $stable(operating_mode_word); endproperty
  a_bank: assert property (p_bank) else $error("other bank loaded");
  property p_dec; up_r == 2'h3 && $stable(operating_mode_word) |-> mode_fields.latency == operating_mode_word[6:4]
    && mode_fields.interleave == operating_mode_word[3] && mode_fields.eight == (operating_mode_word[2:0] == BLEN_EIGHT);
  endproperty
  a_dec: assert property (p_dec) else $error("decode wrong");
  property p_rec; up_r == 2'h3 && $stable(operating_mode_word) |-> mode_fields.slow_wake == operating_mode_word[12]
    && mode_fields.recover == {1'b0, operating_mode_word[11:9]} + 4'h1;
  endproperty
  a_rec: assert property (p_rec) else $error("recovery decode wrong");
  property p_wake; (pd_active && mode_fields.slow_wake) [*2] |-> slow_wake_sel; endproperty
  a_wake: assert property (p_wake) else $error("slow exit not selected");
  property p_pre; !pd_active ##1 !pd_active |-> !slow_wake_sel; endproperty
  a_pre: assert property (p_pre) else $error("slow exit outside active");
endmodule : dmr_mode_reg_monitor
bind dmr_mode_reg dmr_mode_reg_monitor dmr_mode_reg_monitor_i (.clk, .resetn, .clk_en, .cmd, .bank_addr, .addr,
  .pd_active, .operating_mode_word, .mode_fields, .test_mode, .loop_reset_pulse, .slow_wake_sel);

// ==== tb/dmr_ctrl_model.sv ====
// Memory controller model driving the command pins
`timescale 1ns/100ps
module dmr_ctrl_model
  import dmr_pkg::*;
#(
  parameter int MLG = 4
)
(
  // Clock
  input wire logic clk,
  // Command pins
  output logic [3:0] cmd,
  output logic [BANK_W-1:0] bank_addr,
  output logic [ADDR_W-1:0] addr
);
  ////////////////////////////////////////
  // Idle as no-operation
  initial
  begin
    cmd = 4'h7;
    bank_addr = 3'h0;
    addr = 14'h0;
  end
  // One command for one cycle, then no-operation with the inverse bank and address
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(negedge clk);
    cmd = c;
    bank_addr = b;
    addr = a;
    @(negedge clk);
    cmd = 4'h7;
    bank_addr = ~b;
    addr = ~a;
  endtask : issue
  // Whole word, top bits zero, only with bursts drained
  task automatic load(input logic [12:0] w);
    issue(CMD_MODE_LOAD, 3'h0, {1'b0, w});
    repeat (MLG) @(negedge clk);
  endtask : load
endmodule : dmr_ctrl_model

// ==== tb/tb.sv ====
// Testbench for the mode register block
`timescale 1ns/100ps
module tb
  import dmr_pkg::*;
;
  ////////////////////////////////////////
  logic clk, resetn, clk_en, pd_active, test_mode, loop_reset_pulse, read_data_start, auto_precharge_start;
  logic slow_wake_sel;
  logic [2:0] bank_addr, posted_extra_latency;
  logic [3:0] cmd;
  logic [13:0] addr;
  logic [16:0] operating_mode_word;
  logic [2:0] cols [8];
  dmr_mode_t mode_fields;
  dmr_beat_t beat_out;
  int n_mismatch, check_count, nb, k_rd, k_ap, k_last;
  logic last_w;
  // Design and controller
  dmr_mode_reg dmr_mode_reg_i (.clk, .resetn, .clk_en, .cmd, .bank_addr, .addr, .posted_extra_latency,
    .pd_active, .operating_mode_word, .mode_fields, .test_mode, .loop_reset_pulse, .beat_out,
    .read_data_start, .auto_precharge_start, .slow_wake_sel);
  dmr_ctrl_model dmr_ctrl_model_i (.clk, .cmd, .bank_addr, .addr);
  always #5 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // Mode word from its fields
  function automatic logic [12:0] mw(input logic b8, il, input logic [2:0] cl, input logic [3:0] wr, input logic wk);
    return {wk, 3'(wr - 4'h1), 2'h0, cl, il, b8 ? BLEN_EIGHT : BLEN_FOUR};
  endfunction : mw
  // One read or write, sampled for sixty cycles
  task automatic burst(input logic [3:0] c, input logic [13:0] a);
    nb = 0;
    k_rd = -1;
    k_ap = -1;
    last_w = (c != CMD_WRITE);
    dmr_ctrl_model_i.issue(c, 3'h0, a);
    for (int k = 0; k < 60; k++)
    begin
      if (beat_out.valid === 1'b1)
      begin
        if (nb < 8) cols[nb] = beat_out.col;
        nb++;
        k_last = k;
        last_w = beat_out.is_write;
      end
      if (read_data_start === 1'b1 && k_rd < 0) k_rd = k;
      if (auto_precharge_start === 1'b1) k_ap = k;
      @(negedge clk);
    end
  endtask : burst
  ////////////////////////////////////////
  task automatic t_fields;
    logic [12:0] w;
    chk(operating_mode_word, MODE_RESET);
    for (int cl = 3; cl < 8; cl++)
    begin
      w = mw(cl[0], cl[1], 3'(cl), 4'(cl + 1), cl[2]);
      dmr_ctrl_model_i.load(w);
      chk(operating_mode_word, {4'h0, w});
      chk(mode_fields, dmr_mode_t'({cl[0], cl[1], 3'(cl), 4'(cl + 1), cl[2]}));
    end
    repeat (50) @(negedge clk);
    chk(operating_mode_word, {4'h0, w});
    $display("t_fields done");
  endtask : t_fields
  task automatic t_dll;
    int n;
    n = 0;
    dmr_ctrl_model_i.issue(CMD_MODE_LOAD, 3'h0, 14'h0332);
    for (int k = 0; k < 8; k++)
    begin
      n += int'(loop_reset_pulse === 1'b1);
      @(negedge clk);
    end
    chk(17'(n), 17'h1);
    chk(operating_mode_word, 17'h00232);
    repeat (200) @(negedge clk);
    dmr_ctrl_model_i.issue(CMD_MODE_LOAD, 3'h0, 14'h1fff);
    dmr_ctrl_model_i.issue(CMD_MODE_LOAD, 3'h1, 14'h0e7b);
    repeat (4) @(negedge clk);
    chk(operating_mode_word, 17'h00232);
    chk(17'(test_mode), 17'h1);
    dmr_ctrl_model_i.load(13'h0232);
    chk(17'(test_mode), 17'h0);
    // Load offered while the clock enable is low must be lost
    clk_en = 1'b0;
    dmr_ctrl_model_i.issue(CMD_MODE_LOAD, 3'h0, 14'h0b45);
    clk_en = 1'b1;
    repeat (3) @(negedge clk);
    chk(operating_mode_word, 17'h00232);
    chk(17'(loop_reset_pulse), 17'h0);
    $display("t_dll done");
  endtask : t_dll
  task automatic t_order;
    for (int m = 0; m < 4; m++)
    begin
      dmr_ctrl_model_i.load(mw(m[0], m[1], 3'h3, 4'h2, 1'b0));
      for (int s = 0; s < 8; s++)
      begin
        burst(s[0] ? CMD_WRITE : CMD_READ, 14'(s));
        chk(17'(nb), m[0] ? 17'h8 : 17'h4);
        chk(17'(last_w), 17'(s[0]));
        chk(17'(k_ap + 1), 17'h0);
        for (int i = 0; i < 4 + 4 * m[0]; i++)
          chk(17'(cols[i]), 17'({m[0] ? s[2] ^ i[2] : s[2], m[1] ? s[1:0] ^ i[1:0] : 2'(s + i)}));
      end
    end
    $display("t_order done");
  endtask : t_order
  task automatic t_lat;
    for (int al = 0; al < 7; al += 3)
      for (int cl = 3; cl < 8; cl++)
      begin
        posted_extra_latency = 3'(al);
        dmr_ctrl_model_i.load(mw(1'b0, 1'b0, 3'(cl), 4'h2, 1'b0));
        burst(CMD_READ, 14'h0);
        chk(17'(k_rd), 17'(cl + al));
      end
    posted_extra_latency = 3'h0;
    for (int wr = 2; wr < 9; wr++)
    begin
      dmr_ctrl_model_i.load(mw(1'b0, 1'b0, 3'h3, 4'(wr), 1'b0));
      burst(CMD_WRITE, 14'h0400);
      chk(17'(k_ap - k_last), 17'(wr));
    end
    $display("t_lat done");
  endtask : t_lat
  task automatic t_pd;
    for (int wk = 0; wk < 2; wk++)
    begin
      dmr_ctrl_model_i.load(mw(1'b0, 1'b0, 3'h3, 4'h2, wk[0]));
      pd_active = 1'b1;
      repeat (3) @(negedge clk);
      chk(17'(slow_wake_sel), 17'(wk));
      pd_active = 1'b0;
      repeat (3) @(negedge clk);
      chk(17'(slow_wake_sel), 17'h0);
    end
    $display("t_pd done");
  endtask : t_pd
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    clk_en = 1'b1;
    pd_active = 1'b0;
    posted_extra_latency = 3'h0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_fields();
    t_dll();
    t_order();
    t_lat();
    t_pd();
    conclude();
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule : tb
